// ===== inc/sac_regs.vh
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// Register byte offsets
`define SAC_OFF_CTRL       12'h000
`define SAC_OFF_STATUS     12'h004
`define SAC_OFF_VIOL       12'h008
`define SAC_OFF_EDGES      12'h00c
`define SAC_OFF_LATCHES    12'h010

// Control field positions
`define SAC_CTRL_FREEZE    0
`define SAC_CTRL_FORCE_MAX 1

// Status field positions
`define SAC_ST_ATT_LSB     0
`define SAC_ST_SHIFT_LSB   8
`define SAC_ST_SERIAL      16
`define SAC_ST_STROBE      17

// Violation flag positions
`define SAC_V_SCK_FAST     0
`define SAC_V_STB_NARROW   1
`define SAC_V_STB_CLOSE    2
`define SAC_V_PAR_NOT_LOW  3

// Word width and reset values
`define SAC_WORD_W         6
`define SAC_ATT_RESET      6'h3f
`define SAC_CTRL_RESET     2'h0

// Timing, figures in ns and derived cycle counts (least times round up)
`define SAC_CLK_NS         4
`define SAC_T_SCK_NS       70
`define SAC_T_LEW_NS       30
`define SAC_T_LES_NS       600
`define SAC_SCK_CYC        ((`SAC_T_SCK_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_LEW_CYC        ((`SAC_T_LEW_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_LES_CYC        ((`SAC_T_LES_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)

`endif

// ===== rtl/sac_sync.v
`timescale 1ns/1ns
`default_nettype none

module sac_sync #(
  parameter W = 10
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] stable_q;

  // Two flops; first stage read only by the second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= {W{1'b0}};
      stable_q <= {W{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

`default_nettype wire

// ===== rtl/sac_shift.v
`timescale 1ns/1ns
`default_nettype none
`include "sac_regs.vh"

module sac_shift #(
  parameter W = 6
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         shift_en,
  input  wire         bit_in,
  output wire [W-1:0] word
);

  reg [W-1:0] word_q;

  // First bit in ends at the top, so it carries the heaviest weight
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      word_q <= {W{1'b1}};
    else if (shift_en)
      word_q <= {word_q[W-2:0], bit_in};
  end

  assign word = word_q;

endmodule

`default_nettype wire

// ===== rtl/sac_top.v
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sac_regs.vh"

module sac_top #(
  parameter W     = `SAC_WORD_W,
  parameter CNT_W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        serial_clk,
  input  wire        serial_data_in,
  input  wire        word_strobe,
  input  wire        interface_select,
  input  wire        att_bit_16db,
  input  wire        att_bit_8db,
  input  wire        att_bit_4db,
  input  wire        att_bit_2db,
  input  wire        att_bit_1db,
  input  wire        att_bit_half_db,
  output reg  [W-1:0] att_state
);

  localparam integer SCK_CYC_I   = `SAC_SCK_CYC;
  localparam integer STB_W_CYC_I = `SAC_LEW_CYC;
  localparam integer STB_S_CYC_I = `SAC_LES_CYC;
  // Counts cut to the counter width on purpose; all of them fit in eight bits
  localparam [7:0]   SCK_CYC     = SCK_CYC_I[7:0];
  localparam [7:0]   STB_W_CYC   = STB_W_CYC_I[7:0];
  localparam [7:0]   STB_S_CYC   = STB_S_CYC_I[7:0];

  // Saturating counters, used for timing and statistics
  function [7:0] sat_inc8;
    input [7:0] v;
    begin
      sat_inc8 = (v == 8'hff) ? v : v + 8'h01;
    end
  endfunction

  function [CNT_W-1:0] sat_inc_cnt;
    input [CNT_W-1:0] v;
    begin
      sat_inc_cnt = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  wire [9:0]   pins_raw;
  wire [9:0]   pins_s;
  wire         sclk_s;
  wire         sdata_s;
  wire         strobe_s;
  wire         serial_mode;
  wire [W-1:0] par_word;
  wire [W-1:0] shift_word;
  wire         sclk_rise;
  wire         shift_en;
  wire         strobe_rise;
  wire         strobe_fall;

  reg          sclk_prev_q;
  reg          strobe_prev_q;
  reg  [1:0]   ctrl_q;
  reg  [3:0]   viol_q;
  reg  [3:0]   viol_d;
  reg  [3:0]   viol_set;
  reg  [7:0]   sck_gap_q;
  reg  [7:0]   stb_width_q;
  reg  [7:0]   stb_space_q;
  reg          stb_seen_q;
  reg  [CNT_W-1:0] edges_q;
  reg  [CNT_W-1:0] latches_q;
  reg  [W-1:0] att_d;
  reg  [31:0]  rd_data;
  reg          rd_err;

  // Pins arrive from the host's domain, so everything goes through the synchroniser
  assign pins_raw = {serial_clk, serial_data_in, word_strobe, interface_select,
                     att_bit_16db, att_bit_8db, att_bit_4db, att_bit_2db,
                     att_bit_1db, att_bit_half_db};

  sac_sync #(
    .W        (10)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  assign sclk_s      = pins_s[9];
  assign sdata_s     = pins_s[8];
  assign strobe_s    = pins_s[7];
  assign serial_mode = pins_s[6];
  assign par_word    = pins_s[5:0];

  // Edge history of the synchronised clock and strobe
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_prev_q   <= 1'b0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q   <= sclk_s;
      strobe_prev_q <= strobe_s;
    end
  end

  assign sclk_rise   = sclk_s & ~sclk_prev_q;
  assign strobe_rise = strobe_s & ~strobe_prev_q;
  assign strobe_fall = ~strobe_s & strobe_prev_q;
  // Clock masked while strobe high; parallel mode never shifts
  assign shift_en    = sclk_rise & ~strobe_s & serial_mode;

  // Data and clock share the same synchroniser delay, so setup holds
  sac_shift #(
    .W        (W)
  ) u_shift (
    .pclk     (pclk),
    .presetn  (presetn),
    .shift_en (shift_en),
    .bit_in   (sdata_s),
    .word     (shift_word)
  );

  // Next attenuation: level-sensitive transfer while strobe is high
  always @*
  begin
    att_d = att_state;
    if (strobe_s && !ctrl_q[`SAC_CTRL_FREEZE])
    begin
      if (serial_mode)
        att_d = shift_word;
      else
        att_d = par_word;
    end
    if (ctrl_q[`SAC_CTRL_FORCE_MAX])
      att_d = `SAC_ATT_RESET;
  end

  // Power-up state is maximum attenuation in every mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      att_state <= `SAC_ATT_RESET;
    else
      att_state <= att_d;
  end

  // Gap since last serial clock edge, to flag a host clock too fast
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_gap_q <= 8'hff;
    else if (sclk_rise)
      sck_gap_q <= 8'h01;
    else
      sck_gap_q <= sat_inc8(sck_gap_q);
  end

  // Strobe width and spacing; first pulse after reset has no spacing check
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stb_width_q <= 8'h00;
      stb_space_q <= 8'h00;
      stb_seen_q  <= 1'b0;
    end
    else
    begin
      if (strobe_rise)
        stb_width_q <= 8'h01;
      else if (strobe_s)
        stb_width_q <= sat_inc8(stb_width_q);
      if (strobe_fall)
      begin
        stb_space_q <= 8'h01;
        stb_seen_q  <= 1'b1;
      end
      else if (!strobe_s)
        stb_space_q <= sat_inc8(stb_space_q);
    end
  end

  // Host-side misbehaviour is only reported, never acted on
  always @*
  begin
    viol_set = 4'h0;
    viol_set[`SAC_V_SCK_FAST]    = sclk_rise && (sck_gap_q < SCK_CYC);
    viol_set[`SAC_V_STB_NARROW]  = strobe_fall && (stb_width_q < STB_W_CYC);
    viol_set[`SAC_V_STB_CLOSE]   = strobe_rise && stb_seen_q && (stb_space_q < STB_S_CYC);
    viol_set[`SAC_V_PAR_NOT_LOW] = serial_mode && (par_word != {W{1'b0}});
  end

  // Write-one-to-clear; a new event in the clearing cycle still sets
  always @*
  begin
    viol_d = viol_q;
    if (psel && penable && pready && pwrite && (paddr == `SAC_OFF_VIOL))
      viol_d = viol_q & ~pwdata[3:0];
    viol_d = viol_d | viol_set;
  end

  // Event statistics
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      viol_q    <= 4'h0;
      edges_q   <= {CNT_W{1'b0}};
      latches_q <= {CNT_W{1'b0}};
    end
    else
    begin
      viol_q <= viol_d;
      if (shift_en)
        edges_q <= sat_inc_cnt(edges_q);
      if (strobe_rise)
        latches_q <= sat_inc_cnt(latches_q);
    end
  end

  // Read mux; unmapped addresses answer with an error and zero data
  always @*
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr)
      `SAC_OFF_CTRL:
        rd_data[1:0] = ctrl_q;
      `SAC_OFF_STATUS:
      begin
        rd_data[`SAC_ST_ATT_LSB +: W]   = att_state;
        rd_data[`SAC_ST_SHIFT_LSB +: W] = shift_word;
        rd_data[`SAC_ST_SERIAL]         = serial_mode;
        rd_data[`SAC_ST_STROBE]         = strobe_s;
      end
      `SAC_OFF_VIOL:
        rd_data[3:0] = viol_q;
      `SAC_OFF_EDGES:
        rd_data[CNT_W-1:0] = edges_q;
      `SAC_OFF_LATCHES:
        rd_data[CNT_W-1:0] = latches_q;
      default:
        rd_err = 1'b1;
    endcase
  end

  // APB slave: one wait state, so every access completes on its second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_q  <= `SAC_CTRL_RESET;
    end
    else
    begin
      if (psel && penable && !pready)
      begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end
      else
      begin
        pready  <= 1'b0;
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
      if (psel && penable && pready && pwrite && (paddr == `SAC_OFF_CTRL))
        ctrl_q <= pwdata[1:0];
    end
  end

endmodule

`default_nettype wire

// ===== test/sac_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sac_chk #(
  parameter W = 6
) (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         word_strobe,
  input wire logic         interface_select,
  input wire logic [W-1:0] att_state
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Strobe held in serial mode, long enough to clear the synchroniser
  sequence s_hold;
    (interface_select && word_strobe)[*6];
  endsequence
  // Strobe low long enough that no transfer is still in flight
  sequence s_low;
    (!word_strobe)[*6];
  endsequence
  // Bus answer shape
  AST_ONE_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("wait state count wrong");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ACK_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_UNMAPPED: assert property (pready && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("idle bus not clear");
  // Attenuation state
  AST_POWERUP: assert property ($rose(presetn) |-> att_state == 6'h3f)
    else $error("power-up state not maximum");
  AST_LOW_HOLDS: assert property (s_low |-> $stable(att_state))
    else $error("state moved with strobe low");
  AST_SER_HOLD: assert property (s_hold |=> $stable(att_state))
    else $error("state moved under held strobe");
endmodule
bind sac_top sac_chk #(.W(W)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .word_strobe(word_strobe),
  .interface_select(interface_select), .att_state(att_state)
);
`default_nettype wire

// ===== test/sac_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "sac_regs.vh"
module sac_host (
  input  wire logic       pclk,
  output var  logic       sclk,
  output var  logic       sdat,
  output var  logic       strobe,
  output var  logic       sel,
  output var  logic [5:0] pins
);
  // Serial mode at start, link clock parked low
  initial
  begin
    sclk = 1'b0;
    sdat = 1'b0;
    strobe = 1'b0;
    sel = 1'b1;
    pins = 6'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Serial word: n bits MSB first, then a strobe carrying k masked clocks
  task automatic send(input logic [7:0] w, input int n, input int k);
    int i;
    sel <= 1'b1;
    pins <= 6'h00;
    for (i = n - 1; i >= 0; i--)
    begin
      sdat <= w[i];
      tick(8);
      sclk <= 1'b1;
      tick(8);
      sclk <= 1'b0;
    end
    sdat <= ~sdat;  // No stale bit after release
    tick(4);
    strobe <= 1'b1;
    repeat (2 * k)
    begin
      tick(8);
      sclk <= ~sclk;
    end
    tick(`SAC_LEW_CYC + 4);
    strobe <= 1'b0;
    tick(`SAC_LES_CYC + 2);
  endtask

  // Parallel: mode 0 latched pulse, 1 direct strobe high, 2 pins only
  task automatic par(input logic [5:0] v, input logic [1:0] mode);
    sel <= 1'b0;
    tick(4);
    pins <= v;
    if (mode == 2'h1)
      strobe <= 1'b1;
    if (mode == 2'h0)
    begin
      tick(3);
      strobe <= 1'b1;
      tick(`SAC_LEW_CYC + 4);
      strobe <= 1'b0;
    end
    tick(`SAC_LES_CYC + 2);
  endtask
endmodule
`default_nettype wire

// ===== test/sac_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "sac_regs.vh"
module sac_top_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        sdat;
  logic        strobe;
  logic        sel;
  logic [5:0]  pins;
  logic [5:0]  att;
  int          mismatches = 0;
  int          checked = 0;
  int          i;

  // System clock
  always #2 pclk = ~pclk;

  sac_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(sclk), .serial_data_in(sdat), .word_strobe(strobe), .interface_select(sel),
    .att_bit_16db(pins[5]), .att_bit_8db(pins[4]), .att_bit_4db(pins[3]),
    .att_bit_2db(pins[2]), .att_bit_1db(pins[1]), .att_bit_half_db(pins[0]), .att_state(att)
  );
  sac_host i_host (.pclk(pclk), .sclk(sclk), .sdat(sdat), .strobe(strobe), .sel(sel), .pins(pins));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus transfer; bounded wait so a dead slave cannot hang the run
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
    chk("pslverr", {31'h0, pslverr}, {31'h0, err});
    if (!w)
      chk("prdata", prdata, d);
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, well past the expected run
  initial
  begin
    #200000;
    mismatches++;
    test_done;
  end

  // Reset, registers, serial words, then parallel modes
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("att", att, 32'h3f);
    xfer(1'h0, `SAC_OFF_STATUS, 32'h13f3f, 1'h0);
    xfer(1'h0, 12'h020, 32'h0, 1'h1);
    xfer(1'h1, `SAC_OFF_LATCHES, 32'hffff, 1'h0);
    xfer(1'h0, `SAC_OFF_LATCHES, 32'h0, 1'h0);
    i_host.send(8'h2d, 6, 0);
    chk("att", att, 32'h2d);
    i_host.send(8'hd2, 8, 0);
    chk("att", att, 32'h12);
    i_host.send(8'h00, 0, 3);
    chk("att", att, 32'h12);
    i_host.send(8'h00, 0, 0);
    chk("att", att, 32'h12);
    xfer(1'h0, `SAC_OFF_EDGES, 32'he, 1'h0);
    xfer(1'h0, `SAC_OFF_LATCHES, 32'h4, 1'h0);
    xfer(1'h0, `SAC_OFF_STATUS, 32'h11212, 1'h0);
    xfer(1'h0, `SAC_OFF_VIOL, 32'h1, 1'h0);
    xfer(1'h1, `SAC_OFF_VIOL, 32'h1, 1'h0);
    xfer(1'h0, `SAC_OFF_VIOL, 32'h0, 1'h0);
    i_host.par(6'h05, 2'h0);
    chk("att", att, 32'h05);
    i_host.par(6'h3a, 2'h2);
    chk("att", att, 32'h05);
    for (i = 0; i < 6; i++)
    begin
      i_host.par(6'h01 << i, 2'h1);
      chk("att", att, 32'h1 << i);
    end
    // Control bits with strobe held high: force maximum, freeze, then release
    xfer(1'h1, `SAC_OFF_CTRL, 32'h2, 1'h0);
    xfer(1'h0, `SAC_OFF_CTRL, 32'h2, 1'h0);
    chk("att", att, 32'h3f);
    xfer(1'h1, `SAC_OFF_CTRL, 32'h1, 1'h0);
    i_host.par(6'h0a, 2'h1);
    chk("att", att, 32'h3f);
    xfer(1'h1, `SAC_OFF_CTRL, 32'h0, 1'h0);
    xfer(1'h0, `SAC_OFF_STATUS, 32'h2120a, 1'h0);
    chk("att", att, 32'h0a);
    test_done;
  end
endmodule
`default_nettype wire
